//--- common/smon_pkg.sv
// Package for the supply monitor control and interrupt logic
package smon_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] STAT_OFF   = 8'h04;
  localparam logic [7:0] MASK_OFF   = 8'h08;
  localparam logic [7:0] CORE_OFF   = 8'h0c;
  localparam logic [7:0] FLAGS_OFF  = 8'h10;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int THR_LSB       = 0;
  localparam int DET_ON_BIT    = 4;
  localparam int LOW_STAT_BIT  = 5;
  localparam int EVT_LOW_BIT   = 0;
  localparam int EVT_WAKE_BIT  = 1;
  localparam int GIE_BIT       = 0;
  localparam int GRP_EN_BIT    = 1;
  localparam int SRC_EN_BIT    = 2;
  localparam int SRC_FLAG_BIT  = 0;
  localparam int GRP_FLAG_BIT  = 1;

  // ------------------------------------------------------------
  // Reset values and widths
  // ------------------------------------------------------------
  localparam logic [2:0] THR_RST    = 3'h0;
  localparam logic       DET_ON_RST = 1'b0;
  localparam logic [1:0] MASK_RST   = 2'h0;
  localparam int         PC_W       = 13;
  localparam int         CNT_W      = 16;
  localparam int         EVT_W      = 2;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 4;
  localparam int IRQ_DELAY_NS     = 100;
  localparam int IRQ_DELAY_CYC    =
    (IRQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // Threshold codes
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    SMON_V1P8 = 3'h0, SMON_V2P0 = 3'h1, SMON_V2P4 = 3'h2, SMON_V2P7 = 3'h3,
    SMON_V3P0 = 3'h4, SMON_V3P3 = 3'h5, SMON_V3P6 = 3'h6, SMON_V4P0 = 3'h7
  } smon_thr_t;

  // ------------------------------------------------------------
  // Core handshake carrier
  // ------------------------------------------------------------
  typedef struct packed {
    logic            ack;
    logic            ret;
    logic            return_from_interrupt;
    logic [PC_W-1:0] pc;
  } smon_core_t;

  // ------------------------------------------------------------
  // Whole state of the block
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0]       thr;
    logic             det_on;
    logic             sync1;
    logic             sync2;
    logic             low_status;
    logic [CNT_W-1:0] dly_cnt;
    logic             dly_done;
    logic             src_flag;
    logic             grp_flag;
    logic             gie;
    logic             grp_en;
    logic             src_en;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] mask;
    logic [1:0]       flag_prev;
    logic             wake;
    logic             irq;
    logic             cpu_irq;
    logic             push;
    logic [PC_W-1:0]  stack_pc;
    logic             det_active;
    logic [31:0]      rdata;
    logic             ready;
    logic             ph_valid;
    logic             ph_write;
    logic [7:0]       ph_addr;
  } smon_state_t;

endpackage : smon_pkg

//--- rtl/smon_top.sv
// Supply monitor control register, delayed request and interrupt servicing logic
//
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps

// Functional notes
// - Source flag stays set until cleared by software; group flag until serviced or cleared
// - Servicing clears the group flag but not the source flag
// - Rising request flag wakes from sleep or idle
// - Entry pushes only the program counter
// - Return-from-interrupt sets global enable; plain return not
// - Bits 2..0 select one of eight thresholds
// - Bit 5 reads one while supply low
// - Bit 4 switches detector on or off
// - Bits 7, 6, 3 read zero
// - Detector off during sleep regardless of enable
// - Request raised after fixed delay from status
// - Supply-low source sits in grouped interrupt
// - Wake-up ignores all enable bits
// - Servicing clears the global enable
module smon_top #(
  parameter int IRQ_DELAY_CYC = smon_pkg::IRQ_DELAY_CYC
) (
  input  wire logic                        clk_in,
  input  wire logic                        sys_rst_in,
  input  wire logic                        hsel_in,
  input  wire logic [31:0]                 haddr_in,
  input  wire logic [1:0]                  htrans_in,
  input  wire logic                        hwrite_in,
  input  wire logic [2:0]                  hsize_in,
  input  wire logic [31:0]                 hwdata_in,
  input  wire logic                        hready_in,
  output logic      [31:0]                 hrdata_out,
  output logic                             hreadyout_out,
  output logic                             hresp_out,
  input  wire logic                        supply_below_in,
  input  wire logic                        sleep_mode_in,
  input  wire logic                        idle_mode_in,
  input  wire smon_pkg::smon_core_t        core_in,
  output logic                             detector_power_out,
  output logic      [2:0]                  threshold_level_out,
  output logic                             cpu_irq_out,
  output logic                             stack_push_out,
  output logic      [smon_pkg::PC_W-1:0]   stack_pc_out,
  output logic                             wake_out,
  output logic                             irq_out
);

  localparam logic [smon_pkg::CNT_W-1:0] DLY_LAST =
    smon_pkg::CNT_W'(IRQ_DELAY_CYC - 1);

  smon_pkg::smon_state_t st_reg;
  smon_pkg::smon_state_t st_next;

  // ------------------------------------------------------------
  // Register read decode
  // ------------------------------------------------------------
  function automatic logic [31:0] smon_read(input smon_pkg::smon_state_t s,
                                            input logic [7:0] addr);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (addr == smon_pkg::CTRL_OFF) begin
      d[smon_pkg::THR_LSB +: 3]      = s.thr;
      d[smon_pkg::DET_ON_BIT]        = s.det_on;
      d[smon_pkg::LOW_STAT_BIT]      = s.low_status;
    end else if (addr == smon_pkg::STAT_OFF) begin
      d[smon_pkg::EVT_W-1:0]         = s.evt;
    end else if (addr == smon_pkg::MASK_OFF) begin
      d[smon_pkg::EVT_W-1:0]         = s.mask;
    end else if (addr == smon_pkg::CORE_OFF) begin
      d[smon_pkg::GIE_BIT]           = s.gie;
      d[smon_pkg::GRP_EN_BIT]        = s.grp_en;
      d[smon_pkg::SRC_EN_BIT]        = s.src_en;
    end else if (addr == smon_pkg::FLAGS_OFF) begin
      d[smon_pkg::SRC_FLAG_BIT]      = s.src_flag;
      d[smon_pkg::GRP_FLAG_BIT]      = s.grp_flag;
    end
    return d;
  endfunction : smon_read

  // ------------------------------------------------------------
  // Register write decode
  // ------------------------------------------------------------
  function automatic logic smon_wr_hit(input logic       is_wr,
                                       input logic [7:0] addr,
                                       input logic [7:0] off);
    return is_wr && (addr == off);
  endfunction : smon_wr_hit

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic       wr;
    logic [7:0] wa;
    logic [1:0] flags_now;
    logic       src_set;
    logic       grp_set;
    logic       low_rise;
    logic       taken;
    wr        = 1'b0;
    wa        = 8'h00;
    flags_now = 2'h0;
    src_set   = 1'b0;
    grp_set   = 1'b0;
    low_rise  = 1'b0;
    taken     = 1'b0;
    st_next   = st_reg;

    // ----------------------------------------------------------
    // Bus slave: every transfer gets one wait state so reads see prior writes
    // ----------------------------------------------------------
    st_next.ready = 1'b1;
    if (st_reg.ph_valid) begin
      st_next.ph_valid = 1'b0;
      st_next.ready    = 1'b1;
      if (st_reg.ph_write) begin
        wr = 1'b1;
        wa = st_reg.ph_addr;
      end else begin
        st_next.rdata = smon_read(st_reg, st_reg.ph_addr);
      end
    end else if (st_reg.ready && hready_in && hsel_in && htrans_in[1]) begin
      st_next.ph_valid = 1'b1;
      st_next.ph_write = hwrite_in;
      st_next.ph_addr  = {haddr_in[7:2], 2'b00};
      st_next.ready    = 1'b0;
    end

    // ----------------------------------------------------------
    // Comparator synchroniser
    // ----------------------------------------------------------
    st_next.sync1 = supply_below_in;
    st_next.sync2 = st_reg.sync1;

    // ----------------------------------------------------------
    // Detector power and status
    // ----------------------------------------------------------
    st_next.det_active = st_reg.det_on && !sleep_mode_in;
    st_next.low_status = st_reg.det_active && st_reg.sync2;

    // ----------------------------------------------------------
    // Delay from status set to request
    // ----------------------------------------------------------
    if (!st_reg.low_status) begin
      st_next.dly_cnt  = '0;
      st_next.dly_done = 1'b0;
    end else if (!st_reg.dly_done) begin
      if (st_reg.dly_cnt == DLY_LAST) begin
        src_set          = 1'b1;
        st_next.dly_done = 1'b1;
      end else begin
        st_next.dly_cnt = st_reg.dly_cnt + 1'b1;
      end
    end

    // ----------------------------------------------------------
    // Software writes
    // ----------------------------------------------------------
    if (smon_wr_hit(wr, wa, smon_pkg::CTRL_OFF)) begin
      st_next.thr    = hwdata_in[smon_pkg::THR_LSB +: 3];
      st_next.det_on = hwdata_in[smon_pkg::DET_ON_BIT];
    end
    if (smon_wr_hit(wr, wa, smon_pkg::MASK_OFF)) begin
      st_next.mask = hwdata_in[smon_pkg::EVT_W-1:0];
    end
    if (smon_wr_hit(wr, wa, smon_pkg::CORE_OFF)) begin
      st_next.gie    = hwdata_in[smon_pkg::GIE_BIT];
      st_next.grp_en = hwdata_in[smon_pkg::GRP_EN_BIT];
      st_next.src_en = hwdata_in[smon_pkg::SRC_EN_BIT];
    end
    if (smon_wr_hit(wr, wa, smon_pkg::FLAGS_OFF)) begin
      st_next.src_flag = hwdata_in[smon_pkg::SRC_FLAG_BIT];
      st_next.grp_flag = hwdata_in[smon_pkg::GRP_FLAG_BIT];
    end

    // ----------------------------------------------------------
    // Group flag follows a newly requesting enabled member
    // ----------------------------------------------------------
    grp_set = src_set && st_reg.src_en && !st_reg.src_flag;

    // ----------------------------------------------------------
    // Servicing of the grouped request
    // ----------------------------------------------------------
    taken = core_in.ack && st_reg.cpu_irq;
    if (taken) begin
      st_next.grp_flag = 1'b0;
      st_next.gie      = 1'b0;
      st_next.stack_pc = core_in.pc;
    end
    st_next.push = taken;
    if (core_in.return_from_interrupt) begin
      st_next.gie = 1'b1;
    end

    // ----------------------------------------------------------
    // Hardware sets win over clears
    // ----------------------------------------------------------
    if (src_set) begin
      st_next.src_flag = 1'b1;
    end
    if (grp_set) begin
      st_next.grp_flag = 1'b1;
    end

    // ----------------------------------------------------------
    // Wake-up on any rising request flag
    // ----------------------------------------------------------
    flags_now         = {st_reg.grp_flag, st_reg.src_flag};
    st_next.flag_prev = flags_now;
    st_next.wake      = (|(flags_now & ~st_reg.flag_prev))
                        && (sleep_mode_in || idle_mode_in);

    // ----------------------------------------------------------
    // Sticky events, write one to clear, set wins
    // ----------------------------------------------------------
    low_rise = st_reg.src_flag && !st_reg.flag_prev[0];
    if (smon_wr_hit(wr, wa, smon_pkg::STAT_OFF)) begin
      st_next.evt = st_reg.evt & ~hwdata_in[smon_pkg::EVT_W-1:0];
    end
    if (low_rise) begin
      st_next.evt[smon_pkg::EVT_LOW_BIT] = 1'b1;
    end
    if (st_reg.wake) begin
      st_next.evt[smon_pkg::EVT_WAKE_BIT] = 1'b1;
    end
    st_next.irq = |(st_next.evt & st_next.mask);

    // ----------------------------------------------------------
    // Request towards the core
    // ----------------------------------------------------------
    st_next.cpu_irq = st_next.gie && st_next.grp_en && st_next.grp_flag;

    // ----------------------------------------------------------
    // Synchronous reset
    // ----------------------------------------------------------
    if (sys_rst_in) begin
      st_next            = '0;
      st_next.thr        = smon_pkg::THR_RST;
      st_next.det_on     = smon_pkg::DET_ON_RST;
      st_next.mask       = smon_pkg::MASK_RST;
      st_next.ready      = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    st_reg <= st_next;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign hrdata_out          = st_reg.rdata;
  assign hreadyout_out       = st_reg.ready;
  assign hresp_out           = 1'b0;
  assign detector_power_out  = st_reg.det_active;
  assign threshold_level_out = st_reg.thr;
  assign cpu_irq_out         = st_reg.cpu_irq;
  assign stack_push_out      = st_reg.push;
  assign stack_pc_out        = st_reg.stack_pc;
  assign wake_out            = st_reg.wake;
  assign irq_out             = st_reg.irq;

endmodule : smon_top

//--- verif/smon_top_asserts.sv
// Port checker for the supply monitor top
`timescale 1ns/100ps
module smon_top_asserts #(
  parameter int IRQ_DELAY_CYC = smon_pkg::IRQ_DELAY_CYC
) (
  input wire logic                      clk_in, sys_rst_in, hsel_in, hwrite_in, hready_in,
  input wire logic [31:0]               haddr_in, hwdata_in, hrdata_out,
  input wire logic [1:0]                htrans_in,
  input wire logic [2:0]                hsize_in, threshold_level_out,
  input wire logic                      hreadyout_out, hresp_out, supply_below_in,
  input wire logic                      sleep_mode_in, idle_mode_in, detector_power_out,
  input wire smon_pkg::smon_core_t      core_in,
  input wire logic                      cpu_irq_out, stack_push_out, wake_out, irq_out,
  input wire logic [smon_pkg::PC_W-1:0] stack_pc_out
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_resp_okay: assert property (hresp_out == 1'b0)
    else $error("bus error response");
  a_one_wait: assert property (hsel_in && htrans_in[1] && hready_in && hreadyout_out
    |=> !hreadyout_out ##1 hreadyout_out) else $error("wait state count wrong");
  a_push_pc: assert property (core_in.ack && cpu_irq_out |=> stack_push_out &&
    stack_pc_out == $past(core_in.pc)) else $error("pc not pushed");
  a_push_cause: assert property (stack_push_out |->
    $past(core_in.ack && cpu_irq_out)) else $error("push without service");
  a_service_blocks: assert property (core_in.ack && cpu_irq_out && !core_in.return_from_interrupt
    |-> ##[1:2] !cpu_irq_out) else $error("request still up after service");
  a_sleep_power: assert property (sleep_mode_in |=> !detector_power_out)
    else $error("detector powered in sleep");
  a_wake_pulse: assert property (wake_out |=> !wake_out)
    else $error("wake pulse too long");
  a_wake_mode: assert property (wake_out |-> $past(sleep_mode_in || idle_mode_in) ||
    $past(sleep_mode_in || idle_mode_in, 2)) else $error("wake outside low power");
  a_thr_by_bus: assert property ($changed(threshold_level_out) |->
    $past(!hreadyout_out)) else $error("threshold moved without write");
endmodule : smon_top_asserts

bind smon_top smon_top_asserts #(.IRQ_DELAY_CYC(IRQ_DELAY_CYC)) u_chk (
  .clk_in, .sys_rst_in, .hsel_in, .hwrite_in, .hready_in, .haddr_in, .hwdata_in,
  .hrdata_out, .htrans_in, .hsize_in, .threshold_level_out, .hreadyout_out, .hresp_out,
  .supply_below_in, .sleep_mode_in, .idle_mode_in, .detector_power_out, .core_in,
  .cpu_irq_out, .stack_push_out, .wake_out, .irq_out, .stack_pc_out);

//--- verif/test_smon_top.sv
// Self-checking bench of the supply monitor top
`timescale 1ns/100ps
module test_smon_top;
  logic                 clk_in, sys_rst_in, hsel, hwrite, supply, sleep, idle;
  logic [1:0]           htrans;
  logic [31:0]          haddr, hwdata, hrdata, r, d;
  logic                 hrdy, hresp, dpow, cirq, push, wake, irq;
  logic [2:0]           thr;
  logic [12:0]          spc, pc;
  smon_pkg::smon_core_t core;
  int                   seed = 99, n_fail = 0, checks = 0, wakes = 0, w0;
  smon_top #(.IRQ_DELAY_CYC(20)) i_dut (.clk_in, .sys_rst_in, .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
    .hresp_out(hresp), .supply_below_in(supply), .sleep_mode_in(sleep),
    .idle_mode_in(idle), .core_in(core), .detector_power_out(dpow),
    .threshold_level_out(thr), .cpu_irq_out(cirq), .stack_push_out(push),
    .stack_pc_out(spc), .wake_out(wake), .irq_out(irq));
  // ----------------------------------------
  // Bus, compare and verdict tasks
  // ----------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_in);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk_in); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_in); while (hrdy !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(r, e);
  endtask : rc
  task automatic kick(input logic [2:0] k);
    pc = 13'($random(seed));
    @(posedge clk_in);
    core <= {k, pc};
    @(posedge clk_in);
    core <= '0;
    #1;
  endtask : kick
  function automatic logic [31:0] ctrl_exp(input logic [31:0] v, input logic low);
    return {26'h0, low, v[4], 1'b0, v[2:0]};
  endfunction : ctrl_exp
  task automatic print_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // Clock, watchdog and sequence
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in) if (wake === 1'b1) wakes++;
  initial begin
    #40000;
    n_fail++;
    print_verdict();
  end
  initial begin
    {sys_rst_in, hsel, hwrite, supply, sleep, idle} = 6'b100000;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    core = '0;
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rc(smon_pkg::CTRL_OFF, 32'h0);
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      d[2:0] = i[2:0];
      bus(1'b1, smon_pkg::CTRL_OFF, d);
      rc(smon_pkg::CTRL_OFF, ctrl_exp(d, 1'b0));
      chk(thr, 32'(i));
      chk(dpow, d[4]);
    end
    bus(1'b1, 8'h3c, $random(seed));
    rc(8'h3c, 32'h0);
    bus(1'b1, smon_pkg::CORE_OFF, 32'h7);
    bus(1'b1, smon_pkg::MASK_OFF, 32'h1);
    bus(1'b1, smon_pkg::CTRL_OFF, 32'h10);
    supply <= 1'b1;
    repeat (6) @(posedge clk_in);
    rc(smon_pkg::CTRL_OFF, 32'h30);
    rc(smon_pkg::FLAGS_OFF, 32'h0);
    repeat (30) @(posedge clk_in);
    rc(smon_pkg::FLAGS_OFF, 32'h3);
    chk(cirq, 1'b1);
    chk(irq, 1'b1);
    bus(1'b1, smon_pkg::MASK_OFF, 32'h0);
    repeat (2) @(posedge clk_in);
    chk(irq, 1'b0);
    bus(1'b1, smon_pkg::STAT_OFF, 32'h1);
    bus(1'b1, smon_pkg::MASK_OFF, 32'h1);
    repeat (2) @(posedge clk_in);
    chk(irq, 1'b0);
    kick(3'h4);
    chk(push, 1'b1);
    chk(spc, pc);
    rc(smon_pkg::FLAGS_OFF, 32'h1);
    rc(smon_pkg::CORE_OFF, 32'h6);
    kick(3'h2);
    rc(smon_pkg::CORE_OFF, 32'h6);
    kick(3'h1);
    rc(smon_pkg::CORE_OFF, 32'h7);
    bus(1'b1, smon_pkg::CORE_OFF, 32'h0);
    repeat (20) @(posedge clk_in);
    rc(smon_pkg::FLAGS_OFF, 32'h1);
    supply <= 1'b0;
    bus(1'b1, smon_pkg::FLAGS_OFF, 32'h0);
    bus(1'b1, smon_pkg::STAT_OFF, 32'h3);
    idle <= 1'b1;
    w0 = wakes;
    supply <= 1'b1;
    repeat (40) @(posedge clk_in);
    chk(wakes - w0, 1);
    rc(smon_pkg::STAT_OFF, 32'h3);
    supply <= 1'b0;
    repeat (8) @(posedge clk_in);
    bus(1'b1, smon_pkg::FLAGS_OFF, 32'h1);
    w0 = wakes;
    supply <= 1'b1;
    repeat (40) @(posedge clk_in);
    chk(wakes - w0, 0);
    idle <= 1'b0;
    chk(dpow, 1'b1);
    sleep <= 1'b1;
    repeat (8) @(posedge clk_in);
    chk(dpow, 1'b0);
    rc(smon_pkg::CTRL_OFF, 32'h10);
    sleep <= 1'b0;
    bus(1'b1, smon_pkg::CTRL_OFF, 32'h0);
    repeat (2) @(posedge clk_in);
    chk(dpow, 1'b0);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rc(smon_pkg::STAT_OFF, 32'h0);
    rc(smon_pkg::FLAGS_OFF, 32'h0);
    chk(irq, 1'b0);
    print_verdict();
  end
endmodule : test_smon_top
